// [inc/la_pkg.sv]
package capture_pkg;
    localparam int NCH   = 8;
    localparam int AW    = 8;
    localparam int DEPTH = 256;
    localparam int TSW   = 16;
    localparam int RAW   = 8;
    localparam logic [AW:0] FILL_MAX = 9'h100;

    // register byte addresses
    localparam logic [RAW-1:0] A_CTRL    = 8'h00;
    localparam logic [RAW-1:0] A_STATUS  = 8'h04;
    localparam logic [RAW-1:0] A_THRESH  = 8'h08;
    localparam logic [RAW-1:0] A_DIV     = 8'h0C;
    localparam logic [RAW-1:0] A_MATCH   = 8'h10;
    localparam logic [RAW-1:0] A_RANGE   = 8'h14;
    localparam logic [RAW-1:0] A_CNTTGT  = 8'h18;
    localparam logic [RAW-1:0] A_PREFILL = 8'h1C;
    localparam logic [RAW-1:0] A_POSTDLY = 8'h20;
    localparam logic [RAW-1:0] A_QUAL    = 8'h24;
    localparam logic [RAW-1:0] A_IRQST   = 8'h28;
    localparam logic [RAW-1:0] A_IRQMSK  = 8'h2C;
    localparam logic [RAW-1:0] A_RDIDX   = 8'h30;
    localparam logic [RAW-1:0] A_RDWORD  = 8'h34;
    localparam logic [RAW-1:0] A_TRIGPOS = 8'h38;

    // control bits
    localparam int B_START  = 0;
    localparam int B_ABORT  = 1;
    localparam int B_CLKINT = 2;
    localparam int B_EN_LO  = 3;
    localparam int B_EN_HI  = 6;
    localparam int E_VAL    = 0;
    localparam int E_RNG    = 1;
    localparam int E_EXT    = 2;
    localparam int E_CNT    = 3;
    // two-byte fields: value/low in [7:0], mask/high in [15:8]
    localparam int F_LO     = 0;
    localparam int F_HI     = 8;
    // status fields
    localparam int S_ST     = 0;
    localparam int S_TRG    = 3;
    localparam int S_WP     = 8;
    localparam int S_FILL   = 16;
    // interrupt bits
    localparam int I_TRIG   = 0;
    localparam int I_DONE   = 1;
    localparam int IRQW     = 2;

    localparam logic [7:0]  RST_THRESH = 8'h80;
    localparam logic [15:0] RST_DIV    = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PRE  = 3'b001,
        ST_ARM  = 3'b010,
        ST_POST = 3'b011,
        ST_DONE = 3'b100
    } st_t;

    typedef struct packed {
        logic [NCH-1:0] glitch;
        logic [NCH-1:0] data;
        logic [TSW-1:0] ts;
    } smp_t;
endpackage

// [tb/state_capture_module_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module state_capture_module_tb_top;
    import capture_pkg::*;
    logic           clk_sys = 1'b0;
    logic           rst_n   = 1'b0;
    logic [RAW-1:0] addr    = '0;
    logic [31:0]    wdata   = '0;
    logic           wr      = 1'b0;
    logic           rd      = 1'b0;
    logic           xtrig   = 1'b0;
    logic           run     = 1'b0;
    logic [NCH-1:0] val_a   = '0;
    logic [NCH-1:0] val_b   = '0;
    logic [31:0]    rdata;
    logic [NCH-1:0] probe;
    logic           ext_clk;
    logic           trig_out;
    logic           irq;
    logic [7:0]     thresh_lvl;
    int             num_errors = 0;
    int             samples_checked = 0;
    int             edges_a = 0;
    int             seed_v;
    int             div;
    int             n;
    logic [31:0]    st;
    logic [31:0]    w0;
    logic [31:0]    w1;
    logic [7:0]     v;
    logic [NCH-1:0] exp_q[$];

    always #2 clk_sys = ~clk_sys;

    // reference count of target clocks that present the qualified value
    always @(posedge ext_clk) begin
        if (run && probe == val_a) begin
            edges_a++;
            exp_q.push_back(probe);
        end
    end

    target_model i_target_model (.run(run), .val_a(val_a), .val_b(val_b),
        .probe(probe), .ext_clk(ext_clk));

    state_capture_module i_state_capture_module (.CLK_SYS(clk_sys), .RST_N(rst_n),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .PROBE_IN(probe), .EXT_CLK(ext_clk), .XTRIG_IN(xtrig),
        .THRESH_LVL(thresh_lvl), .TRIG_OUT(trig_out), .IRQ(irq));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wreg(input logic [RAW-1:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask

    task automatic rreg(input logic [RAW-1:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd   <= 1'b0;
        @(posedge clk_sys);
        d = rdata;
    endtask

    task automatic wait_st(input logic [2:0] s);
        for (int i = 0; i < 500; i++) begin
            rreg(A_STATUS, st);
            if (st[2:0] === s) return;
        end
        num_errors++;
        final_report();
    endtask

    initial begin
        #200000;
        num_errors++;
        final_report();
    end

    initial begin
        seed_v = $urandom(32'hF8A9);
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk({24'h0, thresh_lvl}, {24'h0, RST_THRESH});
        chk({30'h0, trig_out, irq}, 32'h0);
        rreg(8'hFC, st);
        chk(st, 32'h0);
        rreg(A_IRQMSK, st);
        chk(st, 32'h0);
        v = 8'($urandom);
        wreg(A_THRESH, {24'h0, v});
        rreg(A_THRESH, st);
        chk(st, {24'h0, v});
        chk({24'h0, thresh_lvl}, {24'h0, v});

        // wrap the memory on the internal clock and age the oldest slot
        div = $urandom_range(3);
        val_a <= 8'($urandom);
        wreg(A_DIV, 32'(div));
        wreg(A_QUAL, 32'h0);
        wreg(A_PREFILL, {23'h0, FILL_MAX});
        wreg(A_CTRL, 32'h5);
        wait_st(3'h2);
        chk({23'h0, st[24:16]}, {23'h0, FILL_MAX});
        wreg(A_CTRL, 32'h2);
        rreg(A_STATUS, st);
        wreg(A_RDIDX, {24'h0, st[15:8]});
        rreg(A_RDWORD, w0);
        wreg(A_RDIDX, {24'h0, st[15:8] - 8'h01});
        rreg(A_RDWORD, w1);
        chk({16'h0, w1[15:0] - w0[15:0]}, 32'(255 * (div + 1)));
        chk({16'h0, w0[31:16]}, {24'h0, val_a});

        // one run per trigger event kind
        wreg(A_POSTDLY, 32'h5);
        wreg(A_DIV, 32'h0);
        for (int m = 0; m < 4; m++) begin
            v = 8'($urandom);
            val_a <= v;
            wreg(A_IRQMSK, (m == 0) ? 32'h0 : 32'h3);
            wreg(A_MATCH, {16'h0, 8'hFF, v});
            wreg(A_RANGE, {16'h0, v, v});
            wreg(A_CNTTGT, 32'h3);
            wreg(A_PREFILL, (m == E_EXT) ? 32'hC8 : 32'h4);
            xtrig <= (m == E_EXT);
            repeat (8) @(posedge clk_sys);
            wreg(A_CTRL, 32'h5 | (32'h1 << (B_EN_LO + m)));
            if (m == E_EXT) begin
                rreg(A_STATUS, st);
                chk({28'h0, st[3:0]}, 32'h1);
                chk({31'h0, trig_out}, 32'h0);
            end
            wait_st(3'h4);
            xtrig <= 1'b0;
            chk({31'h0, trig_out}, 32'h1);
            rreg(A_TRIGPOS, w0);
            chk({31'h0, w0[7:0] >= ((m == E_EXT) ? 8'hC8 : 8'h4)}, 32'h1);
            chk({24'h0, st[15:8]}, {24'h0, w0[7:0] + 8'h6});
            chk({31'h0, irq}, {31'h0, m != 0});
            rreg(A_IRQST, w1);
            chk(w1, 32'h3);
            wreg(A_IRQST, 32'h3);
            @(posedge clk_sys);
            chk({31'h0, irq}, 32'h0);
        end

        // external clock with storage qualification on one of two values
        v = 8'($urandom);
        val_a <= v;
        val_b <= ~v;
        wreg(A_QUAL, {16'h0, 8'hFF, v});
        wreg(A_PREFILL, {23'h0, FILL_MAX});
        wreg(A_CTRL, 32'h1);
        edges_a = 0;
        exp_q.delete();
        run <= 1'b1;
        repeat (800) @(posedge clk_sys);
        run <= 1'b0;
        repeat (40) @(posedge clk_sys);
        wreg(A_CTRL, 32'h2);
        rreg(A_STATUS, st);
        n = int'(st[24:16]);
        chk({31'h0, n <= edges_a && n + 2 >= edges_a && n > 0}, 32'h1);
        wreg(A_RDIDX, 32'h0);
        for (int i = 0; i < n; i++) begin
            rreg(A_RDWORD, w0);
            chk({16'h0, w0[31:16]}, {24'h0, v});
            chk({24'h0, w0[23:16]}, {24'h0, exp_q[i]});
        end
        final_report();
    end
endmodule // state_capture_module_tb_top
`default_nettype wire

// [tb/target_model.sv]
`timescale 1ns/100ps
`default_nettype none
module target_model
    import capture_pkg::*;
(
    input  wire logic           run,
    input  wire logic [NCH-1:0] val_a,
    input  wire logic [NCH-1:0] val_b,
    output logic      [NCH-1:0] probe,
    output logic                ext_clk
);
    logic sel   = 1'b0;
    logic clk_r = 1'b0;

    assign ext_clk = clk_r;
    assign probe   = sel ? val_b : val_a;

    // the target clock stands low between frames; data moves on the falling
    // edge so the rising edge the capture uses always finds settled lines
    always begin
        #40;
        if (run) begin
            clk_r = ~clk_r;
            if (!clk_r) sel = ~sel;
        end else begin
            clk_r = 1'b0;
            sel     = 1'b0;
        end
    end
endmodule // target_model
`default_nettype wire

// [verilog/probe_front.sv]
`timescale 1ns/100ps
`default_nettype none
module probe_front
    import capture_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic [NCH-1:0] probe_in,
    input  wire logic           ext_clk,
    input  wire logic           smp_en,
    output logic      [NCH-1:0] dat,
    output logic      [NCH-1:0] glit,
    output logic                ext_rise
);
    logic [NCH:0] pin;
    logic [NCH:0] val;
    logic         ext_prev_r;

    assign pin = {ext_clk, probe_in};

    genvar g;
    generate
        for (g = 0; g <= NCH; g++) begin : g_sync
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic v_r;
            // a change counts only once stages two and three agree
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    v_r  <= 1'b0;
                end else begin
                    s1_r <= pin[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) begin
                        v_r <= s3_r;
                    end
                end
            end
            assign val[g] = v_r;
        end
        for (g = 0; g < NCH; g++) begin : g_glitch
            logic act_r;
            logic last_r;
            logic chg;
            assign chg = g_sync[g].s2_r == g_sync[g].s3_r && g_sync[g].s3_r != val[g];
            // activity since the last sample that left the level unchanged
            assign glit[g] = act_r & (val[g] == last_r);
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    act_r  <= 1'b0;
                    last_r <= 1'b0;
                end else if (smp_en) begin
                    act_r  <= chg;
                    last_r <= val[g];
                end else begin
                    act_r  <= act_r | chg;
                end
            end
        end
    endgenerate

    assign dat = val[NCH-1:0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_prev_r <= 1'b0;
        end else begin
            ext_prev_r <= val[NCH];
        end
    end

    assign ext_rise = val[NCH] & ~ext_prev_r;
endmodule // probe_front
`default_nettype wire

// [verilog/state_capture_module.sv]
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - probe bit is one above software threshold level, zero below it
// - sample clock selects target external clock or internal divided clock
// - internal clocking records glitches between sample points with the data
// - each sample clock captures all channels for trigger and memory
// - every stored sample carries its timestamp
// - trigger checks value match, range match or other-module signal
// - event counter raises trigger when it reaches programmed count
// - trigger starts post-trigger counter with terminal value from setting
// - no trigger, hence no post-trigger storage, before prefill amount written
// - storage qualifier gates writes; unqualified samples are discarded
// - memory is circular; new samples overwrite the oldest once full
// - capture stops when triggered and post counter reaches terminal value
// - fill progress and write pointer readable during acquisition
module state_capture_module
    import capture_pkg::*;
(
    input  wire logic           CLK_SYS,
    input  wire logic           RST_N,
    input  wire logic [RAW-1:0] ADDR,
    input  wire logic [31:0]    WDATA,
    input  wire logic           WR,
    input  wire logic           RD,
    output logic      [31:0]    RDATA,
    input  wire logic [NCH-1:0] PROBE_IN,
    input  wire logic           EXT_CLK,
    input  wire logic           XTRIG_IN,
    output logic      [7:0]     THRESH_LVL,
    output logic                TRIG_OUT,
    output logic                IRQ
);
    st_t            st_r;
    logic           clk_int_r;
    logic [3:0]     en_r;
    logic [7:0]     thresh_r;
    logic [15:0]    div_r;
    logic [15:0]    div_cnt_r;
    logic [NCH-1:0] mval_r;
    logic [NCH-1:0] mmsk_r;
    logic [NCH-1:0] rlo_r;
    logic [NCH-1:0] rhi_r;
    logic [NCH-1:0] qval_r;
    logic [NCH-1:0] qmsk_r;
    logic [15:0]    ctgt_r;
    logic [15:0]    ev_cnt_r;
    logic [AW:0]    pre_r;
    logic [15:0]    post_r;
    logic [15:0]    post_cnt_r;
    logic [AW-1:0]  wptr_r;
    logic [AW:0]    fill_r;
    logic           trig_f_r;
    logic [AW-1:0]  trig_idx_r;
    logic [TSW-1:0] ts_r;
    logic [IRQW-1:0] irq_st_r;
    logic [IRQW-1:0] irq_msk_r;
    logic [AW-1:0]  rd_idx_r;
    logic [31:0]    rdata_r;
    smp_t           mem [DEPTH];

    logic [NCH-1:0] dat_s;
    logic [NCH-1:0] glit_s;
    logic           ext_rise;
    logic           running;
    logic           tick;
    logic           sample_en;
    logic           start_p;
    logic           abort_p;
    logic           val_hit;
    logic           rng_hit;
    logic           cnt_hit;
    logic           trig_now;
    logic           qual;
    logic           wr_mem;
    logic           post_last;
    logic           done_ev;
    smp_t           smp;

    probe_front u_front (
        .clk      (CLK_SYS),
        .rst_n    (RST_N),
        .probe_in (PROBE_IN),
        .ext_clk  (EXT_CLK),
        .smp_en   (sample_en),
        .dat      (dat_s),
        .glit     (glit_s),
        .ext_rise (ext_rise)
    );

    assign start_p = WR && ADDR == A_CTRL && WDATA[B_START];
    assign abort_p = WR && ADDR == A_CTRL && WDATA[B_ABORT];
    assign running = st_r == ST_PRE || st_r == ST_ARM || st_r == ST_POST;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            clk_int_r <= 1'b0;
            en_r      <= 4'h0;
            thresh_r  <= RST_THRESH;
            div_r     <= RST_DIV;
            mval_r    <= 8'h00;
            mmsk_r    <= 8'h00;
            rlo_r     <= 8'h00;
            rhi_r     <= 8'h00;
            qval_r    <= 8'h00;
            qmsk_r    <= 8'h00;
            ctgt_r    <= 16'h0000;
            pre_r     <= 9'h000;
            post_r    <= 16'h0000;
            irq_msk_r <= 2'h0;
        end else if (WR) begin
            case (ADDR)
                A_CTRL: begin
                    clk_int_r <= WDATA[B_CLKINT];
                    en_r      <= WDATA[B_EN_HI:B_EN_LO];
                end
                A_THRESH:  thresh_r <= WDATA[7:0];
                A_DIV:     div_r <= WDATA[15:0];
                A_MATCH: begin
                    mval_r <= WDATA[F_LO+:NCH];
                    mmsk_r <= WDATA[F_HI+:NCH];
                end
                A_RANGE: begin
                    rlo_r <= WDATA[F_LO+:NCH];
                    rhi_r <= WDATA[F_HI+:NCH];
                end
                A_QUAL: begin
                    qval_r <= WDATA[F_LO+:NCH];
                    qmsk_r <= WDATA[F_HI+:NCH];
                end
                A_CNTTGT:  ctgt_r <= WDATA[15:0];
                A_PREFILL: pre_r <= WDATA[AW:0];
                A_POSTDLY: post_r <= WDATA[15:0];
                A_IRQMSK:  irq_msk_r <= WDATA[IRQW-1:0];
                default: ;
            endcase
        end
    end

    // the comparator itself is analog; this drives its reference level
    assign THRESH_LVL = thresh_r;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !running || tick) begin
            div_cnt_r <= 16'h0000;
        end else begin
            div_cnt_r <= 16'(div_cnt_r + 16'h0001);
        end
    end

    assign tick      = running && div_cnt_r == div_r;
    assign sample_en = running && (clk_int_r ? tick : ext_rise);

    // glitch field only carries meaning between internal sample points
    assign smp.glitch = clk_int_r ? glit_s : 8'h00;
    assign smp.data   = dat_s;
    assign smp.ts     = ts_r;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || start_p) begin
            ts_r <= 16'h0000;
        end else begin
            ts_r <= 16'(ts_r + 16'h0001);
        end
    end

    assign val_hit  = ((dat_s ^ mval_r) & mmsk_r) == 8'h00;
    assign rng_hit  = dat_s >= rlo_r && dat_s <= rhi_r;
    assign cnt_hit  = val_hit && 16'(ev_cnt_r + 16'h0001) == ctgt_r;
    assign trig_now = sample_en && st_r == ST_ARM &&
                      ((en_r[E_VAL] && val_hit) || (en_r[E_RNG] && rng_hit) ||
                       (en_r[E_EXT] && XTRIG_IN) || (en_r[E_CNT] && cnt_hit));
    assign qual     = ((dat_s ^ qval_r) & qmsk_r) == 8'h00;
    assign wr_mem   = sample_en && qual;
    assign post_last = st_r == ST_POST && wr_mem &&
                       16'(post_cnt_r + 16'h0001) == post_r;
    assign done_ev  = (trig_now && post_r == 16'h0000) || post_last;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || start_p) begin
            ev_cnt_r <= 16'h0000;
        end else if (st_r == ST_ARM && sample_en && val_hit) begin
            ev_cnt_r <= 16'(ev_cnt_r + 16'h0001);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            st_r <= ST_IDLE;
        end else if (start_p) begin
            st_r <= ST_PRE;
        end else if (abort_p) begin
            st_r <= ST_IDLE;
        end else begin
            case (st_r)
                ST_PRE: begin
                    if (fill_r >= pre_r) begin
                        st_r <= ST_ARM;
                    end
                end
                ST_ARM: begin
                    if (trig_now) begin
                        st_r <= done_ev ? ST_DONE : ST_POST;
                    end
                end
                ST_POST: begin
                    if (post_last) begin
                        st_r <= ST_DONE;
                    end
                end
                ST_IDLE, ST_DONE: st_r <= st_r;
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || start_p) begin
            wptr_r     <= '0;
            fill_r     <= '0;
            trig_f_r   <= 1'b0;
            post_cnt_r <= 16'h0000;
            trig_idx_r <= '0;
        end else begin
            if (wr_mem) begin
                wptr_r <= AW'(wptr_r + 1'b1);
                if (fill_r != FILL_MAX) begin
                    // full width so the count can reach the saturation value
                    fill_r <= (AW+1)'(fill_r + 1'b1);
                end
            end
            if (trig_now) begin
                trig_f_r   <= 1'b1;
                trig_idx_r <= wptr_r;
            end
            if (st_r == ST_POST && wr_mem) begin
                post_cnt_r <= 16'(post_cnt_r + 16'h0001);
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (wr_mem) begin
            mem[wptr_r] <= smp;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            irq_st_r <= 2'h0;
        end else begin
            // a new event beats a clear in the same cycle
            irq_st_r <= (irq_st_r & ~((WR && ADDR == A_IRQST) ? WDATA[IRQW-1:0] : 2'h0))
                        | {done_ev, trig_now};
        end
    end

    assign IRQ      = |(irq_st_r & irq_msk_r);
    assign TRIG_OUT = trig_f_r;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            rd_idx_r <= '0;
        end else if (WR && ADDR == A_RDIDX) begin
            rd_idx_r <= WDATA[AW-1:0];
        end else if (RD && ADDR == A_RDWORD) begin
            rd_idx_r <= AW'(rd_idx_r + 1'b1);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !RD) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= 32'h00000000;
            case (ADDR)
                A_CTRL:    rdata_r[B_EN_HI:B_CLKINT] <= {en_r, clk_int_r};
                A_STATUS: begin
                    rdata_r[S_ST+:3]      <= st_r;
                    rdata_r[S_TRG]        <= trig_f_r;
                    rdata_r[S_WP+:AW]     <= wptr_r;
                    rdata_r[S_FILL+:AW+1] <= fill_r;
                end
                A_THRESH:  rdata_r[7:0] <= thresh_r;
                A_DIV:     rdata_r[15:0] <= div_r;
                A_MATCH:   rdata_r[15:0] <= {mmsk_r, mval_r};
                A_RANGE:   rdata_r[15:0] <= {rhi_r, rlo_r};
                A_QUAL:    rdata_r[15:0] <= {qmsk_r, qval_r};
                A_CNTTGT:  rdata_r[15:0] <= ctgt_r;
                A_PREFILL: rdata_r[AW:0] <= pre_r;
                A_POSTDLY: rdata_r[15:0] <= post_r;
                A_IRQST:   rdata_r[IRQW-1:0] <= irq_st_r;
                A_IRQMSK:  rdata_r[IRQW-1:0] <= irq_msk_r;
                A_RDIDX:   rdata_r[AW-1:0] <= rd_idx_r;
                A_RDWORD:  rdata_r <= mem[rd_idx_r];
                A_TRIGPOS: rdata_r[AW-1:0] <= trig_idx_r;
                default: ;
            endcase
        end
    end

    assign RDATA = rdata_r;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    chk_thresh_level: assert property (WR && ADDR == A_THRESH |=> THRESH_LVL == $past(WDATA[7:0]))
        else $error("threshold level not taken");
    chk_ext_sample: assert property (!clk_int_r && !ext_rise |-> !wr_mem)
        else $error("write without external clock edge");
    chk_glitch_ext: assert property (wr_mem && !clk_int_r |=> mem[$past(wptr_r)].glitch == 8'h00)
        else $error("glitch stored in external mode");
    chk_store_data: assert property (wr_mem |=> mem[$past(wptr_r)].data == $past(dat_s))
        else $error("stored data mismatch");
    chk_store_ts: assert property (wr_mem |=> mem[$past(wptr_r)].ts == $past(ts_r))
        else $error("stored timestamp mismatch");
    chk_trig_post: assert property (trig_now && post_r != 16'h0000 && !start_p && !abort_p
        |=> st_r == ST_POST && trig_f_r && post_cnt_r == 16'h0000)
        else $error("trigger did not start post count");
    chk_cnt_trig: assert property (sample_en && st_r == ST_ARM && en_r[E_CNT] && cnt_hit
        && !start_p && !abort_p |=> trig_f_r)
        else $error("counter reach did not trigger");
    chk_prefill_gate: assert property (st_r == ST_PRE && !start_p && !abort_p ##1 st_r == ST_ARM
        |-> $past(fill_r) >= $past(pre_r))
        else $error("armed before prefill");
    chk_qual_gate: assert property (sample_en && !qual && !start_p |=> $stable(wptr_r))
        else $error("unqualified sample written");
    chk_wrap_ptr: assert property (wr_mem && wptr_r == 8'hFF && !start_p |=> wptr_r == 8'h00)
        else $error("pointer did not wrap");
    chk_post_stop: assert property (post_last && !start_p && !abort_p
        |=> st_r == ST_DONE && !sample_en
        ##1 (st_r == ST_DONE && !sample_en) || $past(start_p || abort_p))
        else $error("capture did not stop");
    chk_fill_prog: assert property (wr_mem && fill_r != FILL_MAX && !start_p
        |=> fill_r == 9'(($past(fill_r)) + 9'h001))
        else $error("fill progress wrong");
    chk_start_clear: assert property (start_p |=> wptr_r == 8'h00 && fill_r == 9'h000
        && !trig_f_r && post_cnt_r == 16'h0000 && st_r == ST_PRE)
        else $error("start did not clear state");

    cov_trigger: cover property (trig_now);
    cov_done: cover property (st_r == ST_POST ##1 st_r == ST_DONE);
    cov_wrap: cover property (wr_mem && fill_r == FILL_MAX);
    cov_glitch: cover property (wr_mem && clk_int_r && smp.glitch != 8'h00);
endmodule // state_capture_module
`default_nettype wire
